// ===== core/uvrm_map.svh
// Register map, field positions, reset values and timing counts of the
// undervoltage reset monitor.
// Assumes an AXI4-Lite master with 32-bit data and a 4-bit byte address.
//
// Overview of operation
// - The monitor is active straight out of reset, before software writes.
// - The monitor watches the supply only while power-disable is clear.
// - With reset-disable clear, a supply below the falling level asks reset.
// - In stop mode the monitor works only while stop-enable is set.
// - Trip-level select one picks the 5-V thresholds, zero the 3-V ones.
// - After power-on reset the trip-level select holds the 3-V set.
// - Selecting 5-V while below its rising level enters reset after a three-cycle settle wait.
// - A reset, once asked, is held until the supply exceeds the rising level or power-disable, reset-disable or stop without stop-enable ends it.
// - The comparator drives a status flag that software can poll.
// - The flag is 1 below the falling level, 0 above the rising level.
// - A system reset clears the status flag whatever the comparator shows.
// - The monitor raises no interrupt of its own accord.
// - When enabled the monitor keeps working and resetting in wait mode.
// - In stop mode with stop-enable set, a reset may end stop mode.
`ifndef UVRM_MAP_SVH
`define UVRM_MAP_SVH
`define UVRM_ADDR_W      4
`define UVRM_OFF_CFG     4'h0
`define UVRM_OFF_STAT    4'h4
`define UVRM_OFF_EVT     4'h8
`define UVRM_OFF_MASK    4'hC
`define UVRM_CFG_RESET   4'h0
`define UVRM_EVT_W       3
`define UVRM_EVT_RESET   3'h0
`define UVRM_EVT_UV_SET  0
`define UVRM_EVT_RST     1
`define UVRM_EVT_UV_CLR  2
`define UVRM_STAT_PAD    6'h00
`define UVRM_CFG_PAD     4'h0
`define UVRM_EVT_PAD     5'h00
`define UVRM_DATA_PAD    24'h000000
`define UVRM_SETTLE_CYC  2'h3
`define UVRM_SETTLE_LAST 2'h1
`define UVRM_RESP_OKAY   2'h0
`define UVRM_RESP_SLVERR 2'h2
`endif

// ===== core/uvrm_pkg.sv
// Types shared by the undervoltage reset monitor.
// Assumes the map header is compiled alongside.
package uvrm_pkg;
  // Configuration byte, lowest field in bit 0.
  typedef struct packed {
    logic trip_sel;
    logic stop_en;
    logic rst_dis;
    logic pwr_dis;
  } uvrm_cfg_t;
  // Reset request sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SETTLE = 2'h1,
    ST_HOLD   = 2'h2
  } uvrm_state_t;
endpackage

// ===== core/uvrm_top.sv
// Undervoltage reset monitor: AXI4-Lite registers, comparator
// synchroniser, hysteresis flag, reset request and event interrupt.
// Assumes comparator outputs are asynchronous and RST_B is system reset.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "uvrm_map.svh"
module uvrm_top
  import uvrm_pkg::*;
(
  // Clock and reset.
  input  wire logic                    REF_CLK,
  input  wire logic                    RST_B,
  // AXI4-Lite write channels.
  input  wire logic [`UVRM_ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic                    S_AXI_AWVALID,
  output logic                         S_AXI_AWREADY,
  input  wire logic [31:0]             S_AXI_WDATA,
  input  wire logic [3:0]              S_AXI_WSTRB,
  input  wire logic                    S_AXI_WVALID,
  output logic                         S_AXI_WREADY,
  output logic [1:0]                   S_AXI_BRESP,
  output logic                         S_AXI_BVALID,
  input  wire logic                    S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [`UVRM_ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic                    S_AXI_ARVALID,
  output logic                         S_AXI_ARREADY,
  output logic [31:0]                  S_AXI_RDATA,
  output logic [1:0]                   S_AXI_RRESP,
  output logic                         S_AXI_RVALID,
  input  wire logic                    S_AXI_RREADY,
  // Analog comparator and power modes.
  input  wire logic                    CMP_BELOW_FALL,
  input  wire logic                    CMP_ABOVE_RISE,
  input  wire logic                    STOP_MODE,
  input  wire logic                    WAIT_MODE,
  // Analog controls, reset request, flag and interrupt.
  output logic                         MON_PWR_DIS,
  output logic                         TRIP_SEL_5V,
  output logic                         RST_REQ,
  output logic                         UV_FLAG,
  output logic                         IRQ
);

  logic                    below_meta_r, below_r, above_meta_r, above_r;
  uvrm_cfg_t               cfg_r, cfg_nxt;
  logic [`UVRM_EVT_W-1:0]  mask_r, mask_nxt, evt_r, evt_nxt, evt_set, evt_clr;
  logic                    flag_r, flag_nxt, irq_r, irq_nxt;
  logic                    trip_prev_r, active, rst_en;
  uvrm_state_t             state_r, state_nxt;
  logic [1:0]              cnt_r, cnt_nxt;
  logic                    rst_req_r, rst_req_nxt;
  logic                    aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [`UVRM_ADDR_W-1:0] waddr_r, waddr_nxt, raddr;
  logic [7:0]              wbyte_r, wbyte_nxt;
  logic                    wlane_r, wlane_nxt;
  logic                    awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic                    bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic                    arrdy_r, arrdy_nxt, do_write, do_read;
  logic [1:0]              bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  // All checks sample on the bus clock and sleep while reset is low.
  default clocking cb_chk @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // Two flops per line; zeros while powered down keep stale samples out.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      below_meta_r <= 1'b0;
      below_r      <= 1'b0;
      above_meta_r <= 1'b0;
      above_r      <= 1'b0;
    end else begin
      below_meta_r <= CMP_BELOW_FALL && !cfg_r.pwr_dis;
      below_r      <= below_meta_r;
      above_meta_r <= CMP_ABOVE_RISE && !cfg_r.pwr_dis;
      above_r      <= above_meta_r;
    end
  end

  // Monitor is live when powered and not stopped without stop-enable.
  assign active = !cfg_r.pwr_dis && (!STOP_MODE || cfg_r.stop_en);
  assign rst_en = active && !cfg_r.rst_dis;

  // AXI4-Lite handshakes: address and data taken in either order.
  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign do_read  = S_AXI_ARVALID && arrdy_r;
  assign raddr    = S_AXI_ARADDR;
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    waddr_nxt  = waddr_r;
    wbyte_nxt  = wbyte_r;
    wlane_nxt  = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (S_AXI_AWVALID && awrdy_r) begin
      aw_got_nxt = 1'b1;
      waddr_nxt  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wrdy_r) begin
      w_got_nxt = 1'b1;
      wbyte_nxt = S_AXI_WDATA[7:0];
      wlane_nxt = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = (waddr_r == `UVRM_OFF_CFG || waddr_r == `UVRM_OFF_STAT ||
                    waddr_r == `UVRM_OFF_EVT || waddr_r == `UVRM_OFF_MASK) ?
                   `UVRM_RESP_OKAY : `UVRM_RESP_SLVERR;
    end else if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
    end
    awrdy_nxt = !aw_got_nxt && !bvalid_nxt;
    wrdy_nxt  = !w_got_nxt && !bvalid_nxt;
  end

  // Read path; a read of the event register clears what it returned.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    evt_clr    = '0;
    if (do_read) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `UVRM_RESP_OKAY;
      unique case (raddr)
        `UVRM_OFF_CFG:  rdata_nxt = {`UVRM_DATA_PAD, `UVRM_CFG_PAD, cfg_r};
        `UVRM_OFF_STAT: rdata_nxt = {`UVRM_DATA_PAD, `UVRM_STAT_PAD,
                                     rst_req_r, flag_r};
        `UVRM_OFF_EVT: begin
          rdata_nxt = {`UVRM_DATA_PAD, `UVRM_EVT_PAD, evt_r};
          evt_clr   = evt_r;
        end
        `UVRM_OFF_MASK: rdata_nxt = {`UVRM_DATA_PAD, `UVRM_EVT_PAD, mask_r};
        default: begin
          rdata_nxt = '0;
          rresp_nxt = `UVRM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
    end
    arrdy_nxt = !rvalid_nxt;
  end

  // Configuration and mask writes through byte lane 0.
  always_comb begin
    cfg_nxt  = cfg_r;
    mask_nxt = mask_r;
    if (do_write && wlane_r && waddr_r == `UVRM_OFF_CFG) begin
      cfg_nxt = uvrm_cfg_t'(wbyte_r[3:0]);
    end
    if (do_write && wlane_r && waddr_r == `UVRM_OFF_MASK) begin
      mask_nxt = wbyte_r[`UVRM_EVT_W-1:0];
    end
  end

  // Hysteresis flag: set below falling, clear above rising or while powered down, else hold.
  always_comb begin
    flag_nxt = flag_r;
    if (cfg_r.pwr_dis) begin
      flag_nxt = 1'b0;
    end else if (active && below_r) begin
      flag_nxt = 1'b1;
    end else if (active && above_r) begin
      flag_nxt = 1'b0;
    end
  end

  // Reset request sequencer with a settle wait after a 5-V select.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ST_IDLE: begin
        if (rst_en && below_r) begin
          state_nxt = ST_HOLD;
        end else if (cfg_r.trip_sel && !trip_prev_r) begin
          state_nxt = ST_SETTLE;
          cnt_nxt   = `UVRM_SETTLE_CYC;
        end
      end
      ST_SETTLE: begin
        cnt_nxt = cnt_r - 2'h1;
        if (rst_en && below_r) begin
          state_nxt = ST_HOLD;
        end else if (cnt_r == `UVRM_SETTLE_LAST) begin
          state_nxt = (rst_en && !above_r) ? ST_HOLD : ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!rst_en || above_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    rst_req_nxt = (state_nxt == ST_HOLD);
  end
  // Sticky events, set wins over the read clear, one bit per loop pass.
  assign evt_set[`UVRM_EVT_UV_SET] = flag_nxt && !flag_r;
  assign evt_set[`UVRM_EVT_RST]    = rst_req_nxt && !rst_req_r;
  assign evt_set[`UVRM_EVT_UV_CLR] = !flag_nxt && flag_r;
  for (genvar i = 0; i < `UVRM_EVT_W; i++) begin : g_evt
    assign evt_nxt[i] = evt_set[i] | (evt_r[i] & ~evt_clr[i]);
  end
  assign irq_nxt = |(evt_nxt & mask_nxt);

  // State registers; reset leaves the monitor enabled at 3-V.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_r       <= `UVRM_CFG_RESET;
      mask_r      <= `UVRM_EVT_RESET;
      evt_r       <= `UVRM_EVT_RESET;
      irq_r       <= 1'b0;
      flag_r      <= 1'b0;
      trip_prev_r <= 1'b0;
      state_r     <= ST_IDLE;
      cnt_r       <= 2'h0;
      rst_req_r   <= 1'b0;
      aw_got_r    <= 1'b0;
      w_got_r     <= 1'b0;
      waddr_r     <= '0;
      wbyte_r     <= 8'h00;
      wlane_r     <= 1'b0;
      awrdy_r     <= 1'b0;
      wrdy_r      <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `UVRM_RESP_OKAY;
      arrdy_r     <= 1'b0;
      rvalid_r    <= 1'b0;
      rresp_r     <= `UVRM_RESP_OKAY;
      rdata_r     <= 32'h00000000;
    end else begin
      cfg_r       <= cfg_nxt;
      mask_r      <= mask_nxt;
      evt_r       <= evt_nxt;
      irq_r       <= irq_nxt;
      flag_r      <= flag_nxt;
      trip_prev_r <= cfg_r.trip_sel;
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      rst_req_r   <= rst_req_nxt;
      aw_got_r    <= aw_got_nxt;
      w_got_r     <= w_got_nxt;
      waddr_r     <= waddr_nxt;
      wbyte_r     <= wbyte_nxt;
      wlane_r     <= wlane_nxt;
      awrdy_r     <= awrdy_nxt;
      wrdy_r      <= wrdy_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arrdy_r     <= arrdy_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // Every output comes straight from a flip-flop.
  assign S_AXI_AWREADY = awrdy_r;
  assign S_AXI_WREADY  = wrdy_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_ARREADY = arrdy_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RRESP   = rresp_r;
  assign S_AXI_RDATA   = rdata_r;
  assign MON_PWR_DIS   = cfg_r.pwr_dis;
  assign TRIP_SEL_5V   = cfg_r.trip_sel;
  assign RST_REQ       = rst_req_r;
  assign UV_FLAG       = flag_r;
  assign IRQ           = irq_r;

  // Checks of the monitor behaviour.
  property p_cfg_after_reset;
    $rose(RST_B) |-> (cfg_r == `UVRM_CFG_RESET) && !TRIP_SEL_5V;
  endproperty
  a_cfg_after_reset: assert property (p_cfg_after_reset)
    else $error("Configuration not at reset value after reset.");
  property p_pwr_off_quiet;
    cfg_r.pwr_dis && $past(cfg_r.pwr_dis) |-> !UV_FLAG && !RST_REQ;
  endproperty
  a_pwr_off_quiet: assert property (p_pwr_off_quiet)
    else $error("Powered-off monitor shows an indication.");
  property p_below_resets;
    (state_r == ST_IDLE) && rst_en && below_r |=> RST_REQ;
  endproperty
  a_below_resets: assert property (p_below_resets)
    else $error("Low supply did not raise the reset request.");
  property p_stop_inactive;
    STOP_MODE && !cfg_r.stop_en && !RST_REQ |=> !RST_REQ;
  endproperty
  a_stop_inactive: assert property (p_stop_inactive)
    else $error("Reset raised in stop mode without stop enable.");
  property p_five_volt_select;
    $rose(cfg_r.trip_sel) && (state_r == ST_IDLE) ##2
    (rst_en && !above_r) [*2] |=> RST_REQ;
  endproperty
  a_five_volt_select: assert property (p_five_volt_select)
    else $error("Selecting 5-V below its rising level did not reset.");
  property p_hold_until_rise;
    RST_REQ && rst_en && !above_r |=> RST_REQ;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise)
    else $error("Reset released before supply exceeded rising level.");
  property p_flag_levels;
    active && below_r |=> UV_FLAG;
  endproperty
  a_flag_levels: assert property (p_flag_levels)
    else $error("Flag not set with supply below falling level.");
  property p_flag_reset;
    $rose(RST_B) |-> !UV_FLAG && !RST_REQ;
  endproperty
  a_flag_reset: assert property (p_flag_reset)
    else $error("Flag not cleared by system reset.");
  property p_no_irq_masked;
    (mask_r == `UVRM_EVT_RESET) && $stable(mask_r) |-> !IRQ;
  endproperty
  a_no_irq_masked: assert property (p_no_irq_masked)
    else $error("Interrupt raised while all events are masked.");
  property p_wait_active;
    WAIT_MODE && !STOP_MODE && !cfg_r.pwr_dis && !cfg_r.rst_dis &&
    below_r |=> RST_REQ;
  endproperty
  a_wait_active: assert property (p_wait_active)
    else $error("Monitor did not reset during wait mode.");
  property p_sync_delay;
    $rose(CMP_BELOW_FALL) && !MON_PWR_DIS ##1 CMP_BELOW_FALL |=> below_r;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Synchroniser delay is not two cycles.");
  c_reset_entry: cover property ($rose(RST_REQ));
  c_settle_reset: cover property ((state_r == ST_SETTLE) ##[1:3] RST_REQ);
  c_polled_flag: cover property (cfg_r.rst_dis && $rose(UV_FLAG));
  c_irq: cover property ($rose(IRQ));
endmodule

// ===== tb/uvrm_supply_model.sv
// Behavioural model of the analog supply comparator beside the monitor.
// Assumes the bench sets the supply level in millivolts; the outputs change
// asynchronously to the bus clock, as a real comparator would.
`timescale 1ns/1ps
module uvrm_supply_model #(
  parameter int FALL_3V_MV = 2600,
  parameter int RISE_3V_MV = 2700,
  parameter int FALL_5V_MV = 4000,
  parameter int RISE_5V_MV = 4150
) (
  // Supply level and analog controls.
  input  wire logic [15:0] supply_mv,
  input  wire logic        mon_pwr_dis,
  input  wire logic        trip_sel_5v,
  // Comparator outputs.
  output logic             cmp_below_fall,
  output logic             cmp_above_rise
);
  int   fall_mv;
  int   rise_mv;
  logic below_live;
  logic above_live;
  logic below_last;
  logic above_last;
  // The threshold pair follows the trip select; rise sits above fall.
  assign fall_mv = trip_sel_5v ? FALL_5V_MV : FALL_3V_MV;
  assign rise_mv = trip_sel_5v ? RISE_5V_MV : RISE_3V_MV;
  // Live comparisons of the supply against both levels.
  assign below_live = int'(supply_mv) < fall_mv;
  assign above_live = int'(supply_mv) > rise_mv;
  // Remember the last outputs seen while the comparator was powered.
  always @(*) begin
    if (!mon_pwr_dis) begin
      below_last = below_live;
      above_last = above_live;
    end
  end
  // Powered down, the outputs are meaningless: show the inverse of the last.
  assign #1.3 cmp_below_fall = mon_pwr_dis ? ~below_last : below_live;
  assign #1.3 cmp_above_rise = mon_pwr_dis ? ~above_last : above_live;
endmodule

// ===== tb/uvrm_top_tb.sv
// Self-checking bench of the undervoltage reset monitor over AXI4-Lite.
// Assumes the comparator model above and a 200 MHz bus clock.
`timescale 1ns/1ps
`include "uvrm_map.svh"
`define UVRM_CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module uvrm_top_tb;
  import uvrm_pkg::*;
  localparam int V_OK = 5000;
  localparam int V_MID = 4100;
  localparam int HYSTERESIS_MARGIN = 2650;
  localparam int V_LOW = 2000;
  logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, cmp_fall, cmp_rise;
  logic        stop_m, wait_m, pwr_dis, sel5, rst_req, uv_flag, irq;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] supply_mv;
  int          mismatches;
  int          num_checks;
  // Device under test.
  uvrm_top dut (
    .REF_CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CMP_BELOW_FALL(cmp_fall), .CMP_ABOVE_RISE(cmp_rise),
    .STOP_MODE(stop_m), .WAIT_MODE(wait_m), .MON_PWR_DIS(pwr_dis),
    .TRIP_SEL_5V(sel5), .RST_REQ(rst_req), .UV_FLAG(uv_flag), .IRQ(irq));
  // Comparator at the far side.
  uvrm_supply_model cmp (
    .supply_mv(supply_mv), .mon_pwr_dis(pwr_dis), .trip_sel_5v(sel5),
    .cmp_below_fall(cmp_fall), .cmp_above_rise(cmp_rise));
  // Clock of 5 ns period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One AXI4-Lite write; address and data offered together.
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_d;
    logic w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw_d && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (!w_d && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // One AXI4-Lite read, checked for an OKAY response.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_d;
    ar_d = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (!ar_d && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_d = 1'b1;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
    `UVRM_CHK(rresp, `UVRM_RESP_OKAY)
  endtask
  // Writes the configuration byte.
  task automatic cfg(input logic [3:0] c);
    wr(`UVRM_OFF_CFG, {28'h0, c}, rsp);
    `UVRM_CHK(rsp, `UVRM_RESP_OKAY)
  endtask
  // Moves the supply, then lets the synchroniser and sequencer settle.
  task automatic vset(input int mv);
    @(posedge clk);
    supply_mv <= mv[15:0];
    repeat (8) @(posedge clk);
  endtask
  // Watchdog well beyond the expected length of the run.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end
  // Main test sequence.
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, stop_m, wait_m} = 42'h0;
    wstrb = 4'hF;
    supply_mv = V_OK[15:0];
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`UVRM_OFF_CFG, rd_v);
    `UVRM_CHK(rd_v, 32'h0)
    `UVRM_CHK(sel5, 1'b0)
    rd(`UVRM_OFF_MASK, rd_v);
    `UVRM_CHK(rd_v, 32'h0)
    $display("test reset_values finished");
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b1)
    `UVRM_CHK(irq, 1'b0)
    vset(HYSTERESIS_MARGIN);
    `UVRM_CHK(rst_req, 1'b1)
    `UVRM_CHK(uv_flag, 1'b1)
    vset(V_OK);
    `UVRM_CHK(rst_req, 1'b0)
    `UVRM_CHK(uv_flag, 1'b0)
    $display("test forced_reset finished");
    cfg(4'h2);
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b0)
    wr(`UVRM_OFF_STAT, 32'hFF, rsp);
    `UVRM_CHK(rsp, `UVRM_RESP_OKAY)
    rd(`UVRM_OFF_STAT, rd_v);
    `UVRM_CHK(rd_v, 32'h1)
    vset(V_OK);
    rd(`UVRM_OFF_STAT, rd_v);
    `UVRM_CHK(rd_v, 32'h0)
    $display("test polled finished");
    cfg(4'h1);
    `UVRM_CHK(pwr_dis, 1'b1)
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b0)
    `UVRM_CHK(uv_flag, 1'b0)
    vset(V_OK);
    cfg(4'h0);
    repeat (2) @(posedge clk);
    `UVRM_CHK(rst_req, 1'b0)
    `UVRM_CHK(uv_flag, 1'b0)
    stop_m <= 1'b1;
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b0)
    vset(V_OK);
    cfg(4'h4);
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b1)
    vset(V_OK);
    stop_m <= 1'b0;
    cfg(4'h0);
    wait_m <= 1'b1;
    vset(V_LOW);
    `UVRM_CHK(rst_req, 1'b1)
    vset(V_OK);
    wait_m <= 1'b0;
    $display("test power_modes finished");
    vset(V_MID);
    `UVRM_CHK(rst_req, 1'b0)
    cfg(4'h8);
    `UVRM_CHK(sel5, 1'b1)
    repeat (8) @(posedge clk);
    `UVRM_CHK(rst_req, 1'b1)
    vset(V_OK);
    `UVRM_CHK(rst_req, 1'b0)
    cfg(4'h0);
    $display("test trip_select finished");
    rd(`UVRM_OFF_EVT, rd_v);
    wr(`UVRM_OFF_MASK, 32'h7, rsp);
    vset(V_LOW);
    `UVRM_CHK(irq, 1'b1)
    rd(`UVRM_OFF_EVT, rd_v);
    `UVRM_CHK(rd_v, 32'h3)
    repeat (3) @(posedge clk);
    `UVRM_CHK(irq, 1'b0)
    vset(V_OK);
    rd(`UVRM_OFF_EVT, rd_v);
    `UVRM_CHK(rd_v, 32'h4)
    wr(`UVRM_OFF_MASK, 32'h0, rsp);
    $display("test events finished");
    cfg(4'h2);
    vset(V_LOW);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    `UVRM_CHK(uv_flag, 1'b0)
    repeat (7) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    `UVRM_CHK(rst_req, 1'b1)
    `UVRM_CHK(sel5, 1'b0)
    vset(V_OK);
    $display("test mid_reset finished");
    complete_run;
  end
endmodule
